/* File: pcs_top.sv */
/*
  Transmit-side connection-request sequencer in packet mode, with APB
  registers for the post-acknowledge delay and early-arbitration depth.
  Assumes user words are presented at a FIFO output (valid plus type
  flags) and taken when read enable is high; acknowledges arrive as
  one-cycle pulses on sw_ack; all inputs synchronous to pclk.
*/
`timescale 1ns/10ps
`include "pcs_defs.svh"
module pcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] tx_word,
  input wire logic tx_valid,
  input wire logic tx_is_crq,
  input wire logic tx_is_header,
  input wire logic abort_req,
  input wire logic post_ack_delay_enable,
  output logic read_enable,
  output logic retransmit_mark,
  output logic [31:0] sw_word,
  output pcs_pkg::pcs_wtype_t sw_type,
  input wire logic sw_ack,
  output logic ack_out,
  input wire logic tx_align_seen,
  input wire logic rx_link_lost,
  input wire logic tx_locked,
  input wire logic rx_locked,
  output logic link_unsync_flag,
  output logic rx_link_good,
  output logic tx_link_good
);
  pcs_pkg::pcs_state_t state_reg;
  pcs_pkg::pcs_state_t state_next;
  logic [3:0] delay_reg;
  logic [4:0] depth_reg;
  logic [31:0] crq_reg;
  logic [31:0] hdr_reg;
  logic hdr_held_reg;
  logic [4:0] wcnt_reg;
  logic [4:0] wcnt_next;
  logic [3:0] dly_cnt_reg;
  logic [3:0] min_cnt_reg;
  logic abort_d_reg;
  logic take;
  logic crq_in;
  logic hdr_in;
  logic abort_rise;
  logic load;
  logic hdr_ready;
  logic pace_emit;
  logic pace_aoa;
  logic apb_setup;
  logic apb_wr;
  logic mapped;
  logic [31:0] rd_mux;

  assign take = tx_valid & read_enable;
  assign crq_in = take & tx_is_crq;
  assign hdr_in = take & tx_is_header;
  assign abort_rise = abort_req & ~abort_d_reg;
  assign load = crq_in & ((state_reg == pcs_pkg::PCS_PASS)
                        | (state_reg == pcs_pkg::PCS_DISCARD));
  assign hdr_ready = (dly_cnt_reg == 4'h0) & (min_cnt_reg == 4'h0);

  // register bus: zero-wait access, setup cycle latches the answer
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pready & pwrite;
  assign mapped = (paddr == `PCS_OFF_DELAY) | (paddr == `PCS_OFF_DEPTH)
                | (paddr == `PCS_OFF_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `PCS_OFF_DELAY: rd_mux[3:0] = delay_reg;
      `PCS_OFF_DEPTH: rd_mux[4:0] = depth_reg;
      `PCS_OFF_STATUS: rd_mux[7:0] = {link_unsync_flag, retransmit_mark,
                                      read_enable, ack_out, 1'b0, state_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      prdata <= apb_setup ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_reg <= `PCS_DELAY_RST;
      depth_reg <= `PCS_DEPTH_RST;
    end else if (apb_wr && paddr == `PCS_OFF_DELAY) begin
      delay_reg <= pwdata[3:0];
    end else if (apb_wr && paddr == `PCS_OFF_DEPTH) begin
      depth_reg <= pwdata[4:0];
    end
  end

  // sequencer state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pcs_pkg::PCS_PASS: begin
        if (abort_rise) begin
          state_next = pcs_pkg::PCS_DISCARD;
        end else if (crq_in) begin
          state_next = pcs_pkg::PCS_WAIT;
        end
      end
      pcs_pkg::PCS_WAIT: begin
        if (abort_rise) begin
          state_next = pcs_pkg::PCS_DISCARD;
        end else if (sw_ack) begin
          state_next = (depth_reg != 5'h00 && !hdr_in) ? pcs_pkg::PCS_ACKED : pcs_pkg::PCS_HDR;
        end else if (hdr_in) begin
          state_next = pcs_pkg::PCS_REPEAT;
        end
      end
      pcs_pkg::PCS_ACKED: begin
        if (abort_rise) begin
          state_next = pcs_pkg::PCS_DISCARD;
        end else if (hdr_in) begin
          state_next = pcs_pkg::PCS_HDR;
        end
      end
      pcs_pkg::PCS_REPEAT: begin
        if (abort_rise) begin
          state_next = pcs_pkg::PCS_DISCARD;
        end else if (sw_ack) begin
          state_next = pcs_pkg::PCS_HDR;
        end
      end
      pcs_pkg::PCS_HDR: begin
        if (abort_rise) begin
          state_next = pcs_pkg::PCS_DISCARD;
        end else if (hdr_ready) begin
          state_next = pcs_pkg::PCS_PASS;
        end
      end
      pcs_pkg::PCS_DISCARD: begin
        if (crq_in) begin
          state_next = pcs_pkg::PCS_WAIT;
        end
      end
      default: state_next = pcs_pkg::PCS_PASS;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pcs_pkg::PCS_PASS;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_d_reg <= 1'b0;
    end else begin
      abort_d_reg <= abort_req;
    end
  end

  // data words taken while the acknowledge is pending
  always_comb begin
    wcnt_next = wcnt_reg;
    if (load) begin
      wcnt_next = 5'h00;
    end else if (state_reg == pcs_pkg::PCS_WAIT && take && !tx_is_header) begin
      wcnt_next = wcnt_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_reg <= 5'h00;
    end else begin
      wcnt_reg <= wcnt_next;
    end
  end

  // read enable follows the next state; waiting allows only depth words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_enable <= 1'b1;
    end else begin
      case (state_next)
        pcs_pkg::PCS_WAIT: read_enable <= wcnt_next < depth_reg;
        pcs_pkg::PCS_REPEAT: read_enable <= 1'b0;
        pcs_pkg::PCS_HDR: read_enable <= 1'b0;
        default: read_enable <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crq_reg <= 32'h0000_0000;
    end else if (load) begin
      crq_reg <= tx_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_reg <= 32'h0000_0000;
    end else if (hdr_in) begin
      hdr_reg <= tx_word;
    end
  end

  // without a held header the real one is read from the fifo after the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_held_reg <= 1'b0;
    end else if (load) begin
      hdr_held_reg <= 1'b0;
    end else if (hdr_in) begin
      hdr_held_reg <= 1'b1;
    end
  end

  // post-acknowledge delay and the floor on read enable after a load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_reg <= 4'h0;
    end else if (sw_ack && (state_reg == pcs_pkg::PCS_WAIT
                         || state_reg == pcs_pkg::PCS_REPEAT)) begin
      dly_cnt_reg <= post_ack_delay_enable ? delay_reg : 4'h0;
    end else if (dly_cnt_reg != 4'h0) begin
      dly_cnt_reg <= dly_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_cnt_reg <= 4'h0;
    end else if (load) begin
      min_cnt_reg <= (depth_reg == 5'h00) ? `PCS_MIN_REN_CYC : 4'h0;
    end else if (min_cnt_reg != 4'h0) begin
      min_cnt_reg <= min_cnt_reg - 4'h1;
    end
  end

  pcs_pacer u_pacer (
    .clk(pclk),
    .rst_n(presetn),
    .load(load),
    .ld_ct(tx_word[`PCS_CT_HI:`PCS_CT_LO]),
    .run(state_reg == pcs_pkg::PCS_REPEAT),
    .recast(crq_reg[`PCS_MD_HI:`PCS_MD_LO] == `PCS_MD_RECAST),
    .ct(crq_reg[`PCS_CT_HI:`PCS_CT_LO]),
    .emit(pace_emit),
    .all_outputs_ack_bit(pace_aoa)
  );

  // words toward the switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_word <= `PCS_IDLE_WORD;
      sw_type <= pcs_pkg::PCS_W_IDLE;
    end else if (abort_rise && state_reg != pcs_pkg::PCS_DISCARD) begin
      sw_word <= {crq_reg[31:`PCS_MAP_HI+1], 16'h0000, crq_reg[`PCS_MAP_LO-1:0]};
      sw_type <= pcs_pkg::PCS_W_CRQ;
    end else begin
      sw_word <= `PCS_IDLE_WORD;
      sw_type <= pcs_pkg::PCS_W_IDLE;
      case (state_reg)
        pcs_pkg::PCS_PASS, pcs_pkg::PCS_DISCARD: begin
          if (load) begin
            sw_word <= tx_word | (32'h1 << `PCS_BRK_BIT) | (32'h1 << `PCS_AOA_BIT);
            sw_type <= pcs_pkg::PCS_W_CRQ;
          end else if (take && state_reg == pcs_pkg::PCS_PASS) begin
            sw_word <= tx_word;
            sw_type <= tx_is_header ? pcs_pkg::PCS_W_HDR : pcs_pkg::PCS_W_DATA;
          end
        end
        pcs_pkg::PCS_WAIT, pcs_pkg::PCS_ACKED: begin
          if (take && !tx_is_header && !tx_is_crq) begin
            sw_word <= tx_word;
            sw_type <= pcs_pkg::PCS_W_DATA;
          end
        end
        pcs_pkg::PCS_REPEAT: begin
          if (pace_emit && !sw_ack) begin
            sw_word <= crq_reg;
            sw_word[`PCS_BRK_BIT] <= 1'b0;
            sw_word[`PCS_AOA_BIT] <= pace_aoa;
            sw_type <= pcs_pkg::PCS_W_CRQ;
          end
        end
        pcs_pkg::PCS_HDR: begin
          if (hdr_ready && hdr_held_reg) begin
            sw_word <= hdr_reg;
            sw_type <= pcs_pkg::PCS_W_HDR;
          end
        end
        default: begin
          sw_word <= `PCS_IDLE_WORD;
          sw_type <= pcs_pkg::PCS_W_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retransmit_mark <= 1'b0;
    end else if (hdr_in && state_reg == pcs_pkg::PCS_WAIT && !sw_ack && !abort_rise) begin
      retransmit_mark <= 1'b1;
    end else if (crq_in || abort_rise) begin
      retransmit_mark <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= sw_ack & (state_reg != pcs_pkg::PCS_DISCARD);
    end
  end

  pcs_link_watch u_link (
    .clk(pclk),
    .rst_n(presetn),
    .tx_align_seen(tx_align_seen),
    .rx_link_lost(rx_link_lost),
    .tx_locked(tx_locked),
    .rx_locked(rx_locked),
    .link_unsync_flag(link_unsync_flag),
    .rx_link_good(rx_link_good),
    .tx_link_good(tx_link_good)
  );

  // cycles since the last load, for checking the read-enable floor
  logic [4:0] since_load_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_load_reg <= 5'h1f;
    end else if (load) begin
      since_load_reg <= 5'h00;
    end else if (since_load_reg != 5'h1f) begin
      since_load_reg <= since_load_reg + 5'h01;
    end
  end

  sequence gap_seq;
    !read_enable && sw_type == pcs_pkg::PCS_W_IDLE
    ##1 read_enable && sw_type == pcs_pkg::PCS_W_HDR;
  endsequence

  a_ack_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_ack && state_reg != pcs_pkg::PCS_DISCARD) |=> ack_out ##1 !ack_out)
    else $error("acknowledge output not one cycle");
  a_first_brk: assert property (@(posedge pclk) disable iff (!presetn)
    (load && !abort_rise) |=> sw_type == pcs_pkg::PCS_W_CRQ && sw_word[`PCS_BRK_BIT])
    else $error("first request lacks break");
  a_repeat_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_type == pcs_pkg::PCS_W_CRQ && $past(state_reg) == pcs_pkg::PCS_REPEAT
     && !$past(abort_rise))
    |-> !sw_word[`PCS_BRK_BIT]
        && (crq_reg[`PCS_MD_HI:`PCS_MD_LO] != `PCS_MD_CAMP || sw_word[`PCS_AOA_BIT]))
    else $error("repeated request bits wrong");
  a_hdr_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == pcs_pkg::PCS_WAIT && hdr_in && !sw_ack && !abort_rise)
    |=> !read_enable && retransmit_mark)
    else $error("header before acknowledge not held");
  a_ren_floor: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(read_enable) && state_reg == pcs_pkg::PCS_PASS
     && $past(state_reg) == pcs_pkg::PCS_HDR && depth_reg == 5'h00)
    |-> since_load_reg > 5'h09)
    else $error("read enable rose too early");
  a_ack_nodelay: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == pcs_pkg::PCS_REPEAT && sw_ack && !abort_req && !post_ack_delay_enable
     && min_cnt_reg == 4'h0) |-> ##2 read_enable)
    else $error("read enable late after acknowledge");
  a_early_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == pcs_pkg::PCS_ACKED && hdr_in && !abort_req && dly_cnt_reg == 4'h0
     && min_cnt_reg == 4'h0) |=> gap_seq)
    else $error("early acknowledge gap wrong");
  a_rtm_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (crq_in && !hdr_in) |=> !retransmit_mark)
    else $error("mark not cleared by request");
  a_abort_null: assert property (@(posedge pclk) disable iff (!presetn)
    (abort_rise && state_reg != pcs_pkg::PCS_DISCARD)
    |=> sw_type == pcs_pkg::PCS_W_CRQ && sw_word[`PCS_MAP_HI:`PCS_MAP_LO] == 16'h0000)
    else $error("abort request bitmap not empty");
endmodule

/* File: pcs_defs.svh */
/*
  Constants of the packet-mode connection-request sequencer: word fields,
  register offsets, reset values and timing counts.
  Assumes inclusion by bare name from every design file that needs them.
*/
// How it works
// - alignment patterns on the transmit link raise the unsync flag
// - receive link loss drives both link-good outputs and the unsync flag high
// - camp-on mode sends the loaded request once, then repeats it, idle-spaced, if a header is read before acknowledge
// - header before acknowledge: drop read enable, raise mark, repeat requests
// - after acknowledge, read enable rises and header follows, optionally delayed
// - delay count 0..15, resets to 6, counts zero when delay enable low
// - camp-on idles between repeated requests equal the spacing field value
// - without early arbitration, read enable rises no sooner than 9 clocks after load
// - early request goes out depth-count words before the packet ends
// - early acknowledge: read enable low one cycle and one idle at packet end
// - first request of a packet has break set, repeats have it clear
// - camp-on mode sets the all-outputs-acknowledge bit on first and repeated requests, not on the abort word
// - mark rises after header read and falls when a new request is seen
// - abort sends a request with empty bitmap and discards data until next request
// - recast mode: header before acknowledge starts counted request words
// - recast count spent: repeat request with all-outputs bit clear until acknowledge
// - recast acknowledge sends header and data under the same delay rule
// - recast count field: 000 gives 1, 001 gives 8, doubling to 512
// - acknowledge output pulses exactly one clock per acknowledge received outside the discard state
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_MD_HI 31
`define PCS_MD_LO 30
`define PCS_CT_HI 29
`define PCS_CT_LO 27
`define PCS_AOA_BIT 26
`define PCS_BRK_BIT 24
`define PCS_MAP_HI 23
`define PCS_MAP_LO 8
`define PCS_MD_CAMP 2'h0
`define PCS_MD_RECAST 2'h1
`define PCS_OFF_DELAY 8'h00
`define PCS_OFF_DEPTH 8'h04
`define PCS_OFF_STATUS 8'h08
`define PCS_DELAY_RST 4'h6
`define PCS_DEPTH_RST 5'h00
`define PCS_MIN_REN_CYC 4'h9
`define PCS_IDLE_WORD 32'h0000_0000
`endif

/* File: pcs_pkg.sv */
/*
  Types of the connection-request sequencer.
  Assumes nothing of its surroundings.
*/
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_PASS = 3'b000,
    PCS_WAIT = 3'b001,
    PCS_ACKED = 3'b010,
    PCS_REPEAT = 3'b011,
    PCS_HDR = 3'b100,
    PCS_DISCARD = 3'b101
  } pcs_state_t;
  typedef enum logic [1:0] {
    PCS_W_IDLE = 2'b00,
    PCS_W_CRQ = 2'b01,
    PCS_W_HDR = 2'b10,
    PCS_W_DATA = 2'b11
  } pcs_wtype_t;
endpackage

/* File: pcs_pacer.sv */
/*
  Paces repeated request words: idle spacing in camp-on mode, word count
  and fall-back to all-outputs-clear words in recast mode.
  Assumes load and run never coincide.
*/
`timescale 1ns/10ps
`include "pcs_defs.svh"
module pcs_pacer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [2:0] ld_ct,
  input wire logic run,
  input wire logic recast,
  input wire logic [2:0] ct,
  output logic emit,
  output logic all_outputs_ack_bit
);
  logic [2:0] idle_cnt_reg;
  logic [9:0] rec_cnt_reg;

  assign emit = recast | (idle_cnt_reg == 3'h0);
  assign all_outputs_ack_bit = ~recast | (rec_cnt_reg != 10'h000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_reg <= 3'h0;
    end else if (load) begin
      idle_cnt_reg <= 3'h0;
    end else if (run && !recast) begin
      idle_cnt_reg <= emit ? ct : idle_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt_reg <= 10'h000;
    end else if (load) begin
      rec_cnt_reg <= (ld_ct == 3'h0) ? 10'h001 : (10'h004 << ld_ct);
    end else if (run && recast && rec_cnt_reg != 10'h000) begin
      rec_cnt_reg <= rec_cnt_reg - 10'h001;
    end
  end

  a_idle_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !recast && emit && ct != 3'h0) |=> !emit)
    else $error("no idle after camp-on request");
  a_recast_eight: assert property (@(posedge clk) disable iff (!rst_n)
    (load && ld_ct == 3'h1) |=> rec_cnt_reg == 10'h008)
    else $error("recast count wrong");
endmodule

/* File: pcs_link_watch.sv */
/*
  Link synchronisation status outputs.
  Assumes loss and lock levels come from the serial alignment logic.
*/
`timescale 1ns/10ps
module pcs_link_watch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_align_seen,
  input wire logic rx_link_lost,
  input wire logic tx_locked,
  input wire logic rx_locked,
  output logic link_unsync_flag,
  output logic rx_link_good,
  output logic tx_link_good
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_unsync_flag <= 1'b0;
      rx_link_good <= 1'b0;
      tx_link_good <= 1'b0;
    end else begin
      link_unsync_flag <= tx_align_seen | rx_link_lost;
      rx_link_good <= rx_link_lost | rx_locked;
      tx_link_good <= rx_link_lost | tx_locked;
    end
  end

  a_rx_loss: assert property (@(posedge clk) disable iff (!rst_n)
    rx_link_lost |=> link_unsync_flag && rx_link_good && tx_link_good)
    else $error("receive loss not flagged");
  a_tx_align: assert property (@(posedge clk) disable iff (!rst_n)
    tx_align_seen |=> link_unsync_flag)
    else $error("alignment patterns not flagged");
endmodule

/* File: pcs_switch_model.sv */
/* switch-side model: acknowledges once a set number of requests is seen.
   Assumes one word per pclk from the sequencer. */
`timescale 1ns/10ps
module pcs_switch_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] sw_word,
  input wire pcs_pkg::pcs_wtype_t sw_type,
  input wire logic [9:0] ack_after,
  output logic sw_ack
);
  logic [9:0] seen;
  logic [9:0] nxt;
  logic live;
  // a release word (empty bitmap) is not a request
  assign live = sw_type == pcs_pkg::PCS_W_CRQ && sw_word[23:8] != 16'h0000;
  // break word is stored and restarts the tally, repeats only add to it
  assign nxt = sw_word[24] ? 10'h001 : seen + 10'h001;
  // outputs are never held back, so no flow control appears here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 10'h000;
      sw_ack <= 1'b0;
    end else begin
      sw_ack <= live && nxt == ack_after;
      if (live) begin
        seen <= nxt;
      end
    end
  end
endmodule

/* File: testbench.sv */
/* self-checking bench of the request sequencer with a switch model.
   Assumes zero-wait APB and one word per clock toward the switch. */
`timescale 1ns/10ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, tx_word = 32'h0, sw_word, rd;
  logic tx_valid = 0, tx_is_crq = 0, tx_is_header = 0, abort_req = 0, dly_en = 0;
  logic read_enable, retransmit_mark, sw_ack, ack_out, unsync, rx_good, tx_good;
  logic tx_align_seen = 0, rx_link_lost = 0, tx_locked = 0, rx_locked = 0;
  logic [9:0] ack_after = 10'h000;
  pcs_pkg::pcs_wtype_t sw_type;
  int bad_count = 0, checked = 0, cyc = 0, hdr_t, ack_t, ack_n, dat_n, t;
  logic [31:0] rq_w[$];
  int rq_t[$];
  pcs_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_is_crq(tx_is_crq), .tx_is_header(tx_is_header), .abort_req(abort_req),
    .post_ack_delay_enable(dly_en), .read_enable(read_enable),
    .retransmit_mark(retransmit_mark), .sw_word(sw_word), .sw_type(sw_type),
    .sw_ack(sw_ack), .ack_out(ack_out), .tx_align_seen(tx_align_seen),
    .rx_link_lost(rx_link_lost), .tx_locked(tx_locked), .rx_locked(rx_locked),
    .link_unsync_flag(unsync), .rx_link_good(rx_good), .tx_link_good(tx_good));
  pcs_switch_model sw (.clk(pclk), .rst_n(presetn), .sw_word(sw_word),
    .sw_type(sw_type), .ack_after(ack_after), .sw_ack(sw_ack));
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sw_type === pcs_pkg::PCS_W_CRQ) begin
      rq_t.push_back(cyc);
      rq_w.push_back(sw_word);
    end
    if (sw_type === pcs_pkg::PCS_W_HDR) hdr_t = cyc;
    if (sw_type === pcs_pkg::PCS_W_DATA) dat_n++;
    if (ack_out === 1'b1) begin
      ack_t = cyc;
      ack_n++;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task put(input logic [31:0] w, input logic c, input logic h);
    tx_word <= w;
    tx_is_crq <= c;
    tx_is_header <= h;
    tx_valid <= 1'b1;
    @(posedge pclk);
    while (read_enable !== 1'b1) @(posedge pclk);
  endtask
  task start(input logic [31:0] w, input logic [9:0] n);
    ack_after <= n;
    put(w, 1'b1, 1'b0);
    rq_w.delete();
    rq_t.delete();
    ack_n = 0;
    hdr_t = 0;
    put(32'h0000_00a5, 1'b0, 1'b1);
    tx_valid <= 1'b0;
  endtask
  task camp_on(input logic e);
    apb(1'b1, 8'h04, 32'h0000_0002);
    dly_en <= e;
    start(32'h1000_0100, 10'h003);
    repeat (3) @(posedge pclk);
    chk("mark", 1, retransmit_mark);
    for (int i = 0; i < 60 && hdr_t == 0; i++) @(posedge pclk);
    chk("requests", 3, rq_w.size());
    chk("first", 32'h1500_0100, rq_w[0]);
    chk("repeat", 32'h1400_0100, rq_w[2]);
    chk("spacing", 3, rq_t[2] - rq_t[1]);
    chk("acks", 1, ack_n);
    chk("delay", e ? 4 : 1, hdr_t - ack_t);
    chk("ren", 1, read_enable);
  endtask
  task recast(input logic [2:0] c, input int n);
    int a;
    int z;
    a = 0;
    z = 0;
    start(32'h4000_0100 | {2'h0, c, 27'h0}, 10'(n + 4));
    for (int i = 0; i < 200 && hdr_t == 0; i++) @(posedge pclk);
    for (int i = 1; i < rq_w.size(); i++) begin
      if (rq_w[i][26]) a++;
      else z++;
    end
    chk("counted", n, a);
    chk("fallback", 1, z > 2);
    chk("header", 1, hdr_t > 0);
  endtask
  task early_ack;
    ack_after <= 10'h001;
    put(32'h0000_0100, 1'b1, 1'b0);
    put(32'h0000_0011, 1'b0, 1'b0);
    put(32'h0000_0012, 1'b0, 1'b0);
    put(32'h0000_00a5, 1'b0, 1'b1);
    tx_valid <= 1'b0;
    @(posedge pclk);
    chk("gap ren", 0, read_enable);
    chk("gap idle", pcs_pkg::PCS_W_IDLE, sw_type);
    @(posedge pclk);
    chk("gap end", 1, read_enable);
    chk("gap hdr", pcs_pkg::PCS_W_HDR, sw_type);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("delay reset", 6, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 1, err);
    apb(1'b1, 8'h00, 32'h0000_00f3);
    apb(1'b0, 8'h00, 32'h0);
    chk("delay value", 3, rd);
    camp_on(1'b0);
    camp_on(1'b1);
    recast(3'h0, 1);
    recast(3'h1, 8);
    apb(1'b1, 8'h04, 32'h0);
    dly_en <= 1'b0;
    ack_after <= 10'h001;
    put(32'h0000_0100, 1'b1, 1'b0);
    t = cyc;
    put(32'h0000_00a5, 1'b0, 1'b1);
    chk("floor", 1, cyc - t >= 9);
    tx_valid <= 1'b0;
    apb(1'b1, 8'h04, 32'h0000_0002);
    early_ack;
    start(32'h0000_0100, 10'h000);
    repeat (4) @(posedge pclk);
    abort_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("release", 0, rq_w[rq_w.size() - 1] & 32'h00ff_ff00);
    chk("mark off", 0, retransmit_mark);
    dat_n = 0;
    put(32'h0000_0077, 1'b0, 1'b0);
    put(32'h0000_0078, 1'b0, 1'b0);
    tx_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("discard", 0, dat_n);
    tx_align_seen <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("unsync", 1, unsync);
    tx_align_seen <= 1'b0;
    rx_link_lost <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("goods", 3, {rx_good, tx_good});
    chk("unsync rx", 1, unsync);
    conclude;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude;
  end
endmodule
